// ---- logic/scapc_map.svh ----
// opcodes, counts, reset values and timing constants of the command block
`ifndef SCAPC_MAP_SVH
`define SCAPC_MAP_SVH
`define SCAPC_OP_SET_ALARM 8'h19
`define SCAPC_OP_READ_ALARM 8'h09
`define SCAPC_OP_ALARM_OFF 8'h29
`define SCAPC_OP_ALARM_ON 8'h39
`define SCAPC_OP_READ_BATT 8'h0c
`define SCAPC_OP_READ_TEMP 8'h1c
`define SCAPC_OP_READ_JACK1 8'h2c
`define SCAPC_OP_READ_JACK2 8'h3c
`define SCAPC_OP_REINIT 8'h0f
`define SCAPC_OP_READ_DIP 8'h0a
`define SCAPC_OP_SET_PFAIL 8'h0b
`define SCAPC_OP_SET_CHARGE 8'h1b
`define SCAPC_OP_READ_SWITCH 8'h08
`define SCAPC_ALARM_BYTES 3'h6
`define SCAPC_ONE_BYTE 3'h1
`define SCAPC_NO_BYTES 3'h0
`define SCAPC_IDX_MONTH 0
`define SCAPC_IDX_DAY 1
`define SCAPC_IDX_HOUR 2
`define SCAPC_IDX_MINUTE 3
`define SCAPC_IDX_SECOND 4
`define SCAPC_IDX_WEEKDAY 5
`define SCAPC_DONT_CARE 8'hff
`define SCAPC_PARAM_MARK 8'h80
`define SCAPC_LOW_NIBBLE 8'h0f
`define SCAPC_BIT7_CLEAR 8'h7f
`define SCAPC_ALARM_RST 8'hff
`define SCAPC_PFAIL_RST 8'h00
`define SCAPC_CHARGE_RST 8'h00
`define SCAPC_IRQ_BURST 4'ha
`define SCAPC_JACK_FS_MV 2000
`define SCAPC_JACK_STEPS 64
`define SCAPC_JACK_MAX 6'h3f
`define SCAPC_CLK_HZ 64'd20000000
`define SCAPC_SEC_PER_HOUR 64'd3600
`define SCAPC_FULL_CHG_HOURS 64'd8
`define SCAPC_FULL_CHG_CYCLES (`SCAPC_FULL_CHG_HOURS * `SCAPC_SEC_PER_HOUR * `SCAPC_CLK_HZ)
`endif

// ---- logic/scapc_pkg.sv ----
// types and opcode helpers shared by both ends
`include "scapc_map.svh"
package scapc_pkg;
  typedef logic [7:0] scapc_byte_t;
  typedef logic [2:0] scapc_cnt_t;
  typedef enum logic [1:0] {SCAPC_DEV_IDLE, SCAPC_DEV_PARAM, SCAPC_DEV_REPLY} scapc_dev_state_t;
  typedef enum logic [1:0] {SCAPC_HOST_IDLE, SCAPC_HOST_SEND, SCAPC_HOST_RECV}
    scapc_host_state_t;

  // parameter bytes that follow each opcode
  function automatic scapc_cnt_t scapc_param_count(input scapc_byte_t op);
    scapc_cnt_t n;
    n = `SCAPC_NO_BYTES;
    case (op)
      `SCAPC_OP_SET_ALARM: n = `SCAPC_ALARM_BYTES;
      `SCAPC_OP_SET_PFAIL, `SCAPC_OP_SET_CHARGE: n = `SCAPC_ONE_BYTE;
      default: n = `SCAPC_NO_BYTES;
    endcase
    return n;
  endfunction

  // reply bytes returned for each opcode
  function automatic scapc_cnt_t scapc_reply_count(input scapc_byte_t op);
    scapc_cnt_t n;
    n = `SCAPC_NO_BYTES;
    case (op)
      `SCAPC_OP_READ_ALARM: n = `SCAPC_ALARM_BYTES;
      `SCAPC_OP_READ_BATT, `SCAPC_OP_READ_TEMP, `SCAPC_OP_READ_JACK1, `SCAPC_OP_READ_JACK2,
      `SCAPC_OP_READ_DIP, `SCAPC_OP_READ_SWITCH: n = `SCAPC_ONE_BYTE;
      default: n = `SCAPC_NO_BYTES;
    endcase
    return n;
  endfunction
endpackage

// ---- logic/scapc_if.sv ----
// byte link between host and housekeeping command block
`timescale 1ns/100ps
interface scapc_if;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_ready;
  logic alarm_irq;
  logic pfail_irq;

  modport dev (
    input cmd_valid, cmd_byte, rsp_ready,
    output cmd_ready, rsp_valid, rsp_byte, alarm_irq, pfail_irq
  );
  modport host (
    output cmd_valid, cmd_byte, rsp_ready,
    input cmd_ready, rsp_valid, rsp_byte, alarm_irq, pfail_irq
  );
endinterface

// ---- logic/scapc_device.sv ----
// housekeeping command interpreter: alarm, analog reads, power and charge control
// Functional notes
// - set alarm 19H: six BCD bytes, month first
// - host sets bit7, uses 24-hour hours
// - all-ones field ignored in alarm compare
// - alarm seconds only in ten-second steps
// - alarm bytes stored without any checking
// - alarm interrupts need enable 39H once
// - read alarm 09H: six bytes, masked nibbles
// - opcode 29H stops alarm interrupts
// - opcode 0CH returns battery voltage byte
// - opcode 1CH returns temperature byte
// - opcode 2CH converts jack one, six bits
// - conversion saturates high, zero when negative
// - opcode 3CH converts bar-code jack likewise
// - opcode 0FH reinitialises the whole block
// - opcode 0AH returns DIP switch settings
// - 0BH sets power-fail level, interrupt below
// - 1BH sets full-charge start voltage
// - adapter: full charge eight hours, trickle
// - opcode 08H returns power/trigger switch state
// - each alarm match gives ten interrupts
`timescale 1ns/100ps
`include "scapc_map.svh"
module scapc_device #(
  parameter logic [63:0] FULL_CHG_CYCLES = `SCAPC_FULL_CHG_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // host link
  scapc_if.dev link,
  // calendar clock, bcd, with one-second tick
  input wire logic sec_tick,
  input wire logic [7:0] rtc_month,
  input wire logic [7:0] rtc_day,
  input wire logic [7:0] rtc_hour,
  input wire logic [7:0] rtc_minute,
  input wire logic [7:0] rtc_second,
  input wire logic [7:0] rtc_weekday,
  // analog readings
  input wire logic [7:0] batt_level,
  input wire logic [7:0] backup_level,
  input wire logic [7:0] temp_level,
  input wire logic signed [15:0] jack1_mv,
  input wire logic signed [15:0] jack2_mv,
  // switches
  input wire logic [7:0] dip_sw,
  input wire logic [7:0] power_trig_sw,
  input wire logic adapter_on,
  // power control
  output logic charge_full,
  output logic charge_trickle,
  output logic reinit_pulse
);
  ////////////////////////////////////////////////////////////////////////////////
  scapc_pkg::scapc_dev_state_t state_ff;
  logic [7:0] opcode_ff;
  logic [2:0] cnt_ff;
  logic [7:0] par_ff [0:5];
  logic [7:0] alarm_ff [0:5];
  logic [7:0] rsp_buf_ff [0:5];
  logic [2:0] rsp_cnt_ff;
  logic [2:0] rsp_idx_ff;
  logic cmd_ready_ff;
  logic rsp_valid_ff;
  logic [7:0] rsp_byte_ff;
  logic alarm_en_ff;
  logic [7:0] pfail_lvl_ff;
  logic [7:0] charge_lvl_ff;
  logic below_ff;
  logic pfail_irq_ff;
  logic [3:0] burst_ff;
  logic alarm_irq_ff;
  logic [39:0] chg_timer_ff;
  logic charge_full_ff;
  logic charge_trickle_ff;
  logic reinit_ff;
  logic take;
  logic done;
  logic [7:0] op_now;
  logic alarm_hit;
  logic [7:0] alarm_read [0:5];
  logic [7:0] rsp_first;

  assign link.cmd_ready = cmd_ready_ff;
  assign link.rsp_valid = rsp_valid_ff;
  assign link.rsp_byte = rsp_byte_ff;
  assign link.alarm_irq = alarm_irq_ff;
  assign link.pfail_irq = pfail_irq_ff;
  assign charge_full = charge_full_ff;
  assign charge_trickle = charge_trickle_ff;
  assign reinit_pulse = reinit_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // jack conversion to top six bits
  function automatic logic [7:0] jack_code(input logic signed [15:0] mv);
    logic [31:0] scaled;
    scaled = 32'h0;
    if (mv < 0) begin
      return 8'h00;
    end
    if (mv >= `SCAPC_JACK_FS_MV) begin
      return {`SCAPC_JACK_MAX, 2'h0};
    end
    scaled = (32'(mv) * `SCAPC_JACK_STEPS) / `SCAPC_JACK_FS_MV;
    return {scaled[5:0], 2'h0};
  endfunction

  // field matches when equal or marked don't care
  function automatic logic fld_hit(input logic [7:0] a, input logic [7:0] now);
    return (a == `SCAPC_DONT_CARE) || (a == now);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // command reception
  assign take = link.cmd_valid && cmd_ready_ff;
  assign op_now = (state_ff == scapc_pkg::SCAPC_DEV_IDLE) ? link.cmd_byte : opcode_ff;
  assign done = take && ((state_ff == scapc_pkg::SCAPC_DEV_IDLE) ?
                (scapc_pkg::scapc_param_count(link.cmd_byte) == `SCAPC_NO_BYTES) :
                (cnt_ff == `SCAPC_ONE_BYTE));

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= scapc_pkg::SCAPC_DEV_IDLE;
      opcode_ff <= 8'h00;
      cnt_ff <= 3'h0;
      cmd_ready_ff <= 1'b0;
      rsp_valid_ff <= 1'b0;
      rsp_byte_ff <= 8'h00;
      rsp_cnt_ff <= 3'h0;
      rsp_idx_ff <= 3'h0;
    end else if (reinit_ff) begin
      state_ff <= scapc_pkg::SCAPC_DEV_IDLE;
      cnt_ff <= 3'h0;
      cmd_ready_ff <= 1'b1;
      rsp_valid_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        scapc_pkg::SCAPC_DEV_IDLE: begin
          cmd_ready_ff <= 1'b1;
          if (take) begin
            opcode_ff <= link.cmd_byte;
            cnt_ff <= scapc_pkg::scapc_param_count(link.cmd_byte);
            if (!done) begin
              state_ff <= scapc_pkg::SCAPC_DEV_PARAM;
            end
          end
        end
        scapc_pkg::SCAPC_DEV_PARAM: begin
          if (take) begin
            cnt_ff <= cnt_ff - 3'h1;
            if (done) begin
              state_ff <= scapc_pkg::SCAPC_DEV_IDLE;
            end
          end
        end
        scapc_pkg::SCAPC_DEV_REPLY: begin
          if (rsp_valid_ff && link.rsp_ready) begin
            if (rsp_idx_ff == rsp_cnt_ff - 3'h1) begin
              state_ff <= scapc_pkg::SCAPC_DEV_IDLE;
              rsp_valid_ff <= 1'b0;
              cmd_ready_ff <= 1'b1;
            end else begin
              rsp_byte_ff <= rsp_buf_ff[rsp_idx_ff + 3'h1];
              rsp_idx_ff <= rsp_idx_ff + 3'h1;
            end
          end
        end
      endcase
      if (done && scapc_pkg::scapc_reply_count(op_now) != `SCAPC_NO_BYTES) begin
        state_ff <= scapc_pkg::SCAPC_DEV_REPLY;
        cmd_ready_ff <= 1'b0;
        rsp_valid_ff <= 1'b1;
        rsp_cnt_ff <= scapc_pkg::scapc_reply_count(op_now);
        rsp_idx_ff <= 3'h0;
        rsp_byte_ff <= rsp_first;
      end
    end
  end

  // parameter capture in arrival order
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 6; i++) begin
        par_ff[i] <= 8'h00;
      end
    end else if (take && state_ff == scapc_pkg::SCAPC_DEV_PARAM) begin
      for (int i = 0; i < 5; i++) begin
        par_ff[i] <= par_ff[i + 1];
      end
      par_ff[5] <= link.cmd_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reply snapshot
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      alarm_read[i] = alarm_ff[i];
    end
    alarm_read[`SCAPC_IDX_SECOND] = alarm_ff[`SCAPC_IDX_SECOND] & `SCAPC_LOW_NIBBLE;
    alarm_read[`SCAPC_IDX_WEEKDAY] = alarm_ff[`SCAPC_IDX_WEEKDAY] & `SCAPC_LOW_NIBBLE;
  end

  // first reply byte, sampled as the command completes
  always_comb begin
    rsp_first = alarm_read[0];
    case (op_now)
      `SCAPC_OP_READ_BATT: rsp_first = batt_level;
      `SCAPC_OP_READ_TEMP: rsp_first = temp_level;
      `SCAPC_OP_READ_JACK1: rsp_first = jack_code(jack1_mv);
      `SCAPC_OP_READ_JACK2: rsp_first = jack_code(jack2_mv);
      `SCAPC_OP_READ_DIP: rsp_first = dip_sw;
      `SCAPC_OP_READ_SWITCH: rsp_first = power_trig_sw;
      default: rsp_first = alarm_read[0];
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 6; i++) begin
        rsp_buf_ff[i] <= 8'h00;
      end
    end else if (done) begin
      for (int i = 0; i < 6; i++) begin
        rsp_buf_ff[i] <= alarm_read[i];
      end
      rsp_buf_ff[0] <= rsp_first;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // settings written by commands
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reinit_ff <= 1'b0;
      alarm_en_ff <= 1'b0;
      pfail_lvl_ff <= `SCAPC_PFAIL_RST;
      charge_lvl_ff <= `SCAPC_CHARGE_RST;
      for (int i = 0; i < 6; i++) begin
        alarm_ff[i] <= `SCAPC_ALARM_RST;
      end
    end else begin
      reinit_ff <= done && op_now == `SCAPC_OP_REINIT;
      if (reinit_ff) begin
        alarm_en_ff <= 1'b0;
        pfail_lvl_ff <= `SCAPC_PFAIL_RST;
        charge_lvl_ff <= `SCAPC_CHARGE_RST;
        for (int i = 0; i < 6; i++) begin
          alarm_ff[i] <= `SCAPC_ALARM_RST;
        end
      end else if (done) begin
        case (op_now)
          `SCAPC_OP_SET_ALARM: begin
            for (int i = 0; i < 5; i++) begin
              alarm_ff[i] <= par_ff[i + 1];
            end
            alarm_ff[5] <= link.cmd_byte;
          end
          `SCAPC_OP_ALARM_ON: alarm_en_ff <= 1'b1;
          `SCAPC_OP_ALARM_OFF: alarm_en_ff <= 1'b0;
          `SCAPC_OP_SET_PFAIL: pfail_lvl_ff <= link.cmd_byte;
          `SCAPC_OP_SET_CHARGE: charge_lvl_ff <= link.cmd_byte;
          default: alarm_en_ff <= alarm_en_ff;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alarm compare and interrupt burst
  assign alarm_hit = fld_hit(alarm_ff[`SCAPC_IDX_MONTH], rtc_month) &&
                     fld_hit(alarm_ff[`SCAPC_IDX_DAY], rtc_day) &&
                     fld_hit(alarm_ff[`SCAPC_IDX_HOUR], rtc_hour) &&
                     fld_hit(alarm_ff[`SCAPC_IDX_MINUTE], rtc_minute) &&
                     (alarm_ff[`SCAPC_IDX_SECOND] == `SCAPC_DONT_CARE ||
                      (alarm_ff[`SCAPC_IDX_SECOND] & `SCAPC_LOW_NIBBLE) ==
                      {4'h0, rtc_second[7:4]} && rtc_second[3:0] == 4'h0) &&
                     (alarm_ff[`SCAPC_IDX_WEEKDAY] == `SCAPC_DONT_CARE ||
                      (alarm_ff[`SCAPC_IDX_WEEKDAY] & `SCAPC_LOW_NIBBLE) == rtc_weekday);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      burst_ff <= 4'h0;
      alarm_irq_ff <= 1'b0;
    end else if (reinit_ff || !alarm_en_ff) begin
      burst_ff <= 4'h0;
      alarm_irq_ff <= 1'b0;
    end else if (sec_tick && alarm_hit) begin
      burst_ff <= `SCAPC_IRQ_BURST;
      alarm_irq_ff <= 1'b0;
    end else if (burst_ff != 4'h0 && !alarm_irq_ff) begin
      burst_ff <= burst_ff - 4'h1;
      alarm_irq_ff <= 1'b1;
    end else begin
      alarm_irq_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // power-fail detect on falling below level
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      below_ff <= 1'b0;
      pfail_irq_ff <= 1'b0;
    end else begin
      below_ff <= batt_level < pfail_lvl_ff;
      pfail_irq_ff <= (batt_level < pfail_lvl_ff) && !below_ff && !reinit_ff;
    end
  end

  // charge control
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      chg_timer_ff <= 40'h0;
      charge_full_ff <= 1'b0;
      charge_trickle_ff <= 1'b0;
    end else if (!adapter_on || reinit_ff) begin
      chg_timer_ff <= 40'h0;
      charge_full_ff <= 1'b0;
      charge_trickle_ff <= 1'b0;
    end else if (backup_level < charge_lvl_ff && !charge_full_ff) begin
      chg_timer_ff <= 40'h0;
      charge_full_ff <= 1'b1;
      charge_trickle_ff <= 1'b0;
    end else if (chg_timer_ff >= FULL_CHG_CYCLES[39:0] - 40'h1) begin
      charge_full_ff <= 1'b0;
      charge_trickle_ff <= 1'b1;
    end else begin
      chg_timer_ff <= chg_timer_ff + 40'h1;
      charge_full_ff <= 1'b1;
      charge_trickle_ff <= 1'b0;
    end
  end
endmodule // scapc_device

// ---- logic/scapc_host.sv ----
// host end: sends opcode and parameters, collects reply bytes and interrupts
`timescale 1ns/100ps
`include "scapc_map.svh"
module scapc_host (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link to device
  scapc_if.host link,
  // user request
  input wire logic req_valid,
  input wire logic [7:0] req_op,
  input wire logic [47:0] req_param,
  output logic req_ready,
  // user result
  output logic done,
  output logic [47:0] reply,
  output logic alarm_int,
  output logic pfail_int
);
  ////////////////////////////////////////////////////////////////////////////////
  scapc_pkg::scapc_host_state_t state_ff;
  logic [47:0] par_ff;
  logic [2:0] par_left_ff;
  logic [2:0] rsp_left_ff;
  logic cmd_valid_ff;
  logic [7:0] cmd_byte_ff;
  logic rsp_ready_ff;
  logic req_ready_ff;
  logic done_ff;
  logic [47:0] reply_ff;
  logic alarm_int_ff;
  logic pfail_int_ff;
  logic [2:0] nrsp;
  logic [7:0] op_ff;

  assign link.cmd_valid = cmd_valid_ff;
  assign link.cmd_byte = cmd_byte_ff;
  assign link.rsp_ready = rsp_ready_ff;
  assign req_ready = req_ready_ff;
  assign done = done_ff;
  assign reply = reply_ff;
  assign alarm_int = alarm_int_ff;
  assign pfail_int = pfail_int_ff;
  assign nrsp = scapc_pkg::scapc_reply_count(op_ff);

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= scapc_pkg::SCAPC_HOST_IDLE;
      par_ff <= 48'h0;
      par_left_ff <= 3'h0;
      rsp_left_ff <= 3'h0;
      cmd_valid_ff <= 1'b0;
      cmd_byte_ff <= 8'h00;
      op_ff <= 8'h00;
      rsp_ready_ff <= 1'b0;
      req_ready_ff <= 1'b0;
      done_ff <= 1'b0;
      reply_ff <= 48'h0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        scapc_pkg::SCAPC_HOST_IDLE: begin
          req_ready_ff <= 1'b1;
          if (req_valid && req_ready_ff) begin
            req_ready_ff <= 1'b0;
            cmd_valid_ff <= 1'b1;
            cmd_byte_ff <= req_op;
            op_ff <= req_op;
            par_left_ff <= scapc_pkg::scapc_param_count(req_op);
            par_ff <= req_param;
            if (req_op == `SCAPC_OP_SET_ALARM) begin
              for (int i = 0; i < 6; i++) begin
                par_ff[i * 8 +: 8] <= req_param[i * 8 +: 8] | `SCAPC_PARAM_MARK;
              end
            end
            reply_ff <= 48'h0;
            state_ff <= scapc_pkg::SCAPC_HOST_SEND;
          end
        end
        scapc_pkg::SCAPC_HOST_SEND: begin
          if (link.cmd_ready) begin
            if (par_left_ff != 3'h0) begin
              cmd_byte_ff <= par_ff[7:0];
              par_ff <= {8'h00, par_ff[47:8]};
              par_left_ff <= par_left_ff - 3'h1;
            end else begin
              cmd_valid_ff <= 1'b0;
              rsp_left_ff <= nrsp;
              if (nrsp == `SCAPC_NO_BYTES) begin
                done_ff <= 1'b1;
                state_ff <= scapc_pkg::SCAPC_HOST_IDLE;
              end else begin
                rsp_ready_ff <= 1'b1;
                state_ff <= scapc_pkg::SCAPC_HOST_RECV;
              end
            end
          end
        end
        scapc_pkg::SCAPC_HOST_RECV: begin
          if (link.rsp_valid) begin
            reply_ff <= {link.rsp_byte, reply_ff[47:8]};
            rsp_left_ff <= rsp_left_ff - 3'h1;
            if (rsp_left_ff == 3'h1) begin
              if (nrsp == `SCAPC_ONE_BYTE) begin
                reply_ff <= {40'h0, link.rsp_byte};
              end
              rsp_ready_ff <= 1'b0;
              done_ff <= 1'b1;
              state_ff <= scapc_pkg::SCAPC_HOST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // interrupt lines registered for the user
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_int_ff <= 1'b0;
      pfail_int_ff <= 1'b0;
    end else begin
      alarm_int_ff <= link.alarm_irq;
      pfail_int_ff <= link.pfail_irq;
    end
  end
endmodule // scapc_host

// ---- testbench/scapc_asserts.sv ----
// link checker for the command block
`timescale 1ns/100ps
module scapc_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // link
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_ready,
  input wire logic alarm_irq,
  input wire logic pfail_irq
);
  logic en_ff;
  logic tk;
  assign tk = cmd_valid && cmd_ready;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////
  // alarm enable seen on the link
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) en_ff <= 1'h0;
    else if (tk && cmd_byte == 8'h39) en_ff <= 1'h1;
    else if (tk && cmd_byte == 8'h0f) en_ff <= 1'h0;
  end
  ////////////////////////////////////////
  a_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte))
    else $error("reply not held");
  a_busy_reply: assert property (rsp_valid |-> !cmd_ready)
    else $error("command taken during reply");
  a_irq_pulse: assert property (alarm_irq |=> !alarm_irq)
    else $error("alarm pulse too long");
  a_pfail_pulse: assert property (pfail_irq |=> !pfail_irq)
    else $error("power fail pulse too long");
  a_batt_reply: assert property (tk && cmd_byte == 8'h0c |=> rsp_valid && !cmd_ready)
    else $error("no battery reply");
  a_alarm_read: assert property (tk && cmd_byte == 8'h09 |=> $rose(rsp_valid))
    else $error("no alarm reply");
  a_off_silent: assert property (tk && cmd_byte == 8'h29 |=> !rsp_valid [*2])
    else $error("reply after alarm off");
  a_alarm_gate: assert property (alarm_irq |-> en_ff)
    else $error("alarm before enable");
  c_burst: cover property (alarm_irq ##2 alarm_irq);
  c_pfail: cover property (pfail_irq);
  c_set_alarm: cover property (tk && cmd_byte == 8'h19);
endmodule // scapc_asserts

// ---- testbench/tb_top.sv ----
// self-checking bench for both ends of the command link
`timescale 1ns/100ps
module tb_top;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic req_valid = 1'h0;
  logic [7:0] req_op = 8'h00;
  logic [47:0] req_param = 48'h0;
  logic req_ready, done, alarm_int, pfail_int;
  logic [47:0] reply;
  logic sec_tick = 1'h0;
  logic [7:0] rtc [6] = '{default: 8'hff};
  logic [7:0] batt = 8'hc0, bkup = 8'hff, temp = 8'h00, dip = 8'h00, psw = 8'h00;
  logic signed [15:0] j1 = 16'h0, j2 = 16'h0;
  logic adp = 1'h0;
  logic charge_full, charge_trickle, reinit_pulse;
  int miscompares = 0;
  int n_tests = 0;
  int n_al = 0, n_pf = 0, n_ri = 0, n_ai = 0, n_pi = 0, i, b, pb;
  logic [47:0] ap;
  localparam int jt [6] = '{-300, 0, 250, 1000, 1999, 3000};
  always #25 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  scapc_if link ();
  scapc_device #(.FULL_CHG_CYCLES(64'h64)) scapc_device_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .sec_tick(sec_tick),
    .rtc_month(rtc[0]), .rtc_day(rtc[1]), .rtc_hour(rtc[2]), .rtc_minute(rtc[3]),
    .rtc_second(rtc[4]), .rtc_weekday(rtc[5]), .batt_level(batt), .backup_level(bkup),
    .temp_level(temp), .jack1_mv(j1), .jack2_mv(j2), .dip_sw(dip), .power_trig_sw(psw),
    .adapter_on(adp), .charge_full(charge_full), .charge_trickle(charge_trickle),
    .reinit_pulse(reinit_pulse));
  scapc_host scapc_host_inst (.sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .req_valid(req_valid), .req_op(req_op), .req_param(req_param), .req_ready(req_ready),
    .done(done), .reply(reply), .alarm_int(alarm_int), .pfail_int(pfail_int));
  scapc_asserts scapc_asserts_inst (.sys_clk(sys_clk), .rst_b(rst_b),
    .cmd_valid(link.cmd_valid), .cmd_byte(link.cmd_byte), .cmd_ready(link.cmd_ready),
    .rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte), .rsp_ready(link.rsp_ready),
    .alarm_irq(link.alarm_irq), .pfail_irq(link.pfail_irq));
  ////////////////////////////////////////
  // event counters
  always @(negedge sys_clk) begin
    if (link.alarm_irq === 1'h1) n_al++;
    if (link.pfail_irq === 1'h1) n_pf++;
    if (reinit_pulse === 1'h1) n_ri++;
    if (alarm_int === 1'h1) n_ai++;
    if (pfail_int === 1'h1) n_pi++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // one whole command through the host end
  task automatic cmd(input logic [7:0] op, input logic [47:0] p);
    int k;
    k = 0;
    req_valid <= 1'h1;
    req_op <= op;
    req_param <= p;
    @(posedge sys_clk);
    while (req_ready !== 1'h1 && k < 200) begin
      @(posedge sys_clk);
      k++;
    end
    req_valid <= 1'h0;
    while (done !== 1'h1 && k < 400) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 400) miscompares++;
  endtask
  // one second tick, then count alarm pulses
  task automatic tick(input logic [7:0] s, input int n);
    int c;
    int d;
    rtc[4] <= s;
    @(posedge sys_clk);
    c = n_al;
    d = n_ai;
    sec_tick <= 1'h1;
    @(posedge sys_clk);
    sec_tick <= 1'h0;
    cyc(40);
    chk("alarm irqs", 48'(n), 48'(n_al - c));
    chk("alarm int", 48'(n), 48'(n_ai - d));
  endtask
  function automatic logic [5:0] jexp(input int mv);
    if (mv <= 0) return 6'h00;
    if (mv * 64 / 2000 > 63) return 6'h3f;
    return 6'(mv * 64 / 2000);
  endfunction
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'hcae9da3f));
    cyc(6);
    rst_b <= 1'h1;
    cyc(2);
    cmd(8'h09, 48'h0);
    chk("alarm rst", 48'h0f0fffffffff, reply);
    $display("reset done");
    batt <= 8'($urandom);
    temp <= 8'($urandom);
    dip <= 8'($urandom);
    psw <= 8'($urandom);
    cmd(8'h0c, 48'h0);
    chk("batt", 48'(batt), 48'(reply[7:0]));
    cmd(8'h1c, 48'h0);
    chk("temp", 48'(temp), 48'(reply[7:0]));
    cmd(8'h0a, 48'h0);
    chk("dip", 48'(dip), 48'(reply[7:0]));
    cmd(8'h08, 48'h0);
    chk("switch", 48'(psw), 48'(reply[7:0]));
    $display("reads done");
    for (i = 0; i < 6; i++) begin
      j1 <= 16'(jt[i]);
      j2 <= 16'(jt[5 - i]);
      cmd(8'h2c, 48'h0);
      chk("jack1", 48'(jexp(jt[i])), 48'(reply[7:2]));
      cmd(8'h3c, 48'h0);
      chk("jack2", 48'(jexp(jt[5 - i])), 48'(reply[7:2]));
    end
    $display("jacks done");
    ap = 48'({$urandom, $urandom});
    cmd(8'h19, ap);
    cmd(8'h09, 48'h0);
    chk("alarm", (ap | 48'h808080808080) & 48'h0f0fffffffff, reply);
    foreach (rtc[k])
      rtc[k] <= 8'($urandom);
    cmd(8'h19, 48'hff83ffffffff);
    tick(8'h30, 0);
    cmd(8'h39, 48'h0);
    tick(8'h30, 10);
    tick(8'h31, 0);
    tick(8'h20, 0);
    cmd(8'h29, 48'h0);
    tick(8'h30, 0);
    $display("alarm done");
    batt <= 8'hc0;
    cmd(8'h0b, 48'h90);
    b = n_pf;
    pb = n_pi;
    batt <= 8'h8f;
    cyc(8);
    batt <= 8'h80;
    cyc(8);
    chk("pfail", 48'h1, 48'(n_pf - b));
    chk("pfail int", 48'h1, 48'(n_pi - pb));
    cmd(8'h1b, 48'h90);
    adp <= 1'h1;
    cyc(5);
    chk("full", 48'h2, 48'({charge_full, charge_trickle}));
    cyc(110);
    chk("trickle", 48'h1, 48'({charge_full, charge_trickle}));
    bkup <= 8'h10;
    cyc(5);
    chk("refull", 48'h2, 48'({charge_full, charge_trickle}));
    adp <= 1'h0;
    cyc(5);
    chk("off", 48'h0, 48'({charge_full, charge_trickle}));
    $display("power done");
    b = n_ri;
    cmd(8'h0f, 48'h0);
    cyc(4);
    chk("reinit", 48'h1, 48'(n_ri - b));
    cmd(8'h09, 48'h0);
    chk("alarm rst", 48'h0f0fffffffff, reply);
    cmd(8'h19, 48'hff83ffffffff);
    tick(8'h30, 0);
    $display("reinit done");
    print_verdict();
  end
  // hang guard
  initial begin
    cyc(5000);
    miscompares++;
    print_verdict();
  end
endmodule // tb_top
